//--- sadc_pkg.sv
`default_nettype none
package sadc_pkg;
    // Clock period of the conversion sequencer.
    localparam int unsigned CLK_PERIOD_NS      = 40;
    localparam int unsigned SYNC_STAGES        = 2;
    localparam int unsigned RESULT_BITS        = 16;
    localparam int unsigned BIT_INDEX_BITS     = 4;
    localparam logic [15:0] RESULT_RESET       = 16'h0000;
    localparam logic [15:0] ABORT_WORD         = 16'hff00;
    // Conversion time, a least time, so it rounds up.
    localparam int unsigned CONV_TIME_NS       = 1000;
    localparam int unsigned CONV_CYCLES        = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest response times; the busy and abort ones round down to cycles and are at least one cycle.
    localparam int unsigned BUSY_RISE_MAX_NS   = 20;
    localparam int unsigned BUSY_FALL_MAX_NS   = 5;
    localparam int unsigned ABORT_FALL_MAX_NS  = 10;
    localparam int unsigned SAMPLE_START_MAX_NS = 5;
    localparam int unsigned MSB_RELOAD_MAX_NS  = 18;
    localparam int unsigned BUSY_RISE_CYCLES   = (BUSY_RISE_MAX_NS / CLK_PERIOD_NS > 0) ?
                                                 BUSY_RISE_MAX_NS / CLK_PERIOD_NS : 1;
    localparam int unsigned BUSY_FALL_CYCLES   = (BUSY_FALL_MAX_NS / CLK_PERIOD_NS > 0) ?
                                                 BUSY_FALL_MAX_NS / CLK_PERIOD_NS : 1;
    localparam int unsigned ABORT_FALL_CYCLES  = (ABORT_FALL_MAX_NS / CLK_PERIOD_NS > 0) ?
                                                 ABORT_FALL_MAX_NS / CLK_PERIOD_NS : 1;
    // Full power-down entry time.
    localparam int unsigned PD_ENTRY_US        = 10;
    localparam int unsigned PD_ENTRY_CYCLES    = PD_ENTRY_US * 1000 / CLK_PERIOD_NS;
    // Resume time of untrimmed circuits after power-down release.
    localparam int unsigned RESUME_MS          = 1;
    localparam int unsigned RESUME_CYCLES      = RESUME_MS * 1000000 / CLK_PERIOD_NS;
    // Host-side resume figures.
    localparam int unsigned EXT_REF_RESUME_CONVERSIONS = 2;
    localparam int unsigned INT_REF_RESUME_MS  = 25;
    localparam int unsigned REF_SETTLE_MS      = 4;
    localparam int unsigned TIMER_BITS         = 16;

    typedef enum logic [2:0] {
        SADC_PWRDN,
        SADC_RESUME,
        SADC_WAIT,
        SADC_NAP,
        SADC_SAMPLE,
        SADC_CONVERT
    } sadc_state_t;
endpackage
`default_nettype wire

//--- sadc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sadc_link_if;
    import sadc_pkg::*;
    logic [RESULT_BITS-1:0] frame_word;
    logic                   frame_clear;
    logic                   sdo;

    modport core (
        output frame_word,
        output frame_clear,
        input  sdo
    );
    modport link (
        input  frame_word,
        input  frame_clear,
        output sdo
    );
endinterface
`default_nettype wire

//--- sadc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sadc_sync
    import sadc_pkg::*;
#(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) begin
            $error("Synchroniser width must be at least one.");
        end
    end

    // Two flip-flops per pin; only the second one is read outside.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- sadc_shift.sv
`timescale 1ns/100ps
`default_nettype none
module sadc_shift
    import sadc_pkg::*;
(
    input  wire logic sclk_in,
    sadc_link_if.link lk
);
    logic                      armed_q;
    logic                      shifted_q;
    logic                      bit_q;
    logic                      done_q;
    logic [BIT_INDEX_BITS-1:0] idx_q;
    logic [BIT_INDEX_BITS-1:0] pick;
    logic                      last_bit;

    localparam logic [BIT_INDEX_BITS-1:0] LAST_IDX = BIT_INDEX_BITS'(RESULT_BITS - 2);

    assign last_bit = (idx_q == LAST_IDX);
    assign pick     = LAST_IDX - idx_q;

    // A falling serial clock edge arms the shifter for the next rising edge.
    always_ff @(negedge sclk_in or posedge lk.frame_clear) begin
        if (lk.frame_clear) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= 1'b1;
        end
    end

    // Bits after the first change only on rising serial clock edges.
    always_ff @(posedge sclk_in or posedge lk.frame_clear) begin
        if (lk.frame_clear) begin
            shifted_q <= 1'b0;
            bit_q     <= 1'b0;
            idx_q     <= '0;
            done_q    <= 1'b0;
        end else if (armed_q && !done_q) begin
            shifted_q <= 1'b1;
            bit_q     <= lk.frame_word[pick];
            idx_q     <= last_bit ? idx_q : idx_q + 1'b1;
            done_q    <= last_bit;
        end
    end

    // The first bit shows without any serial clock edge.
    assign lk.sdo = shifted_q ? bit_q : lk.frame_word[RESULT_BITS-1];
endmodule
`default_nettype wire

//--- sadc_top.sv
// Notes on behaviour
// - Busy is high exactly while a conversion runs.
// - Convert start counts only while chip select is low; it is latched.
// - Frame sync counts only while chip select is low.
// - Serial data changes on rising serial clock edges, only with chip select low.
// - Top bit appears without a clock edge; later bits on rising edges.
// - Power-down high resets the logic and powers the device down.
// - Busy rises promptly after a valid convert start.
// - Busy falls promptly when conversion completes.
// - Busy falls promptly after an abort.
// - Sampling starts on qualified convert start rise, or chip select fall; a chip select fall starts it only by giving a qualified rise.
// - Frame sync high at busy fall reloads the new top bit.
// - Full power-down completes a fixed time after power-down asserts.
// - After power-down release the device needs a resume time.
// - Qualified convert start fall mid-conversion aborts; next read gives ff00.
// - Qualified convert start low at conversion end enters nap.
// - Chip select low and convert start high at end gives back-to-back sampling.
`timescale 1ns/100ps
`default_nettype none
module sadc_top
    import sadc_pkg::*;
#(
    parameter int unsigned RESUME_COUNT   = RESUME_CYCLES,
    parameter int unsigned PD_ENTRY_COUNT = PD_ENTRY_CYCLES,
    parameter int unsigned CONV_COUNT     = CONV_CYCLES
) (
    input  wire logic                   clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   sclk_in,
    input  wire logic                   convert_start_n_in,
    input  wire logic                   chip_select_n_in,
    input  wire logic                   frame_sync_in,
    input  wire logic                   power_down_pin_in,
    input  wire logic [RESULT_BITS-1:0] sample_code_in,
    output var  logic                   busy_out,
    output var  logic                   sdo_out,
    output var  logic                   sdo_oe_out,
    output var  logic                   sampling_out,
    output var  logic                   nap_out,
    output var  logic                   powered_down_out,
    output var  logic                   ready_out
);
    initial begin
        if (RESUME_COUNT < 1 || RESUME_COUNT >= (1 << TIMER_BITS) ||
            PD_ENTRY_COUNT < 1 || PD_ENTRY_COUNT >= (1 << TIMER_BITS) ||
            CONV_COUNT < 2 || CONV_COUNT >= (1 << TIMER_BITS)) begin
            $error("Timer counts out of range for the sequencer.");
        end
    end

    sadc_link_if link ();

    logic [3:0] pins_sync;
    logic       cs_n_s;
    logic       convert_start_n_n_s;
    logic       fs_s;
    logic       pd_s;

    sadc_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in ({chip_select_n_in, convert_start_n_in, frame_sync_in, power_down_pin_in}),
        .sync_out (pins_sync)
    );

    assign cs_n_s     = pins_sync[3];
    assign convert_start_n_n_s = pins_sync[2];
    assign fs_s       = pins_sync[1];
    assign pd_s       = pins_sync[0];

    sadc_shift u_shift (
        .sclk_in (sclk_in),
        .lk      (link.link)
    );

    sadc_state_t              state_q;
    sadc_state_t              state_d;
    logic [TIMER_BITS-1:0]    timer_q;
    logic [TIMER_BITS-1:0]    timer_d;
    logic                     qual_q;
    logic                     qual_prev_q;
    logic                     fs_qual_prev_q;
    logic                     cs_n_prev_q;
    logic                     busy_q;
    logic                     busy_prev_q;
    logic                     sampling_q;
    logic                     nap_q;
    logic                     ready_q;
    logic                     pd_done_q;
    logic [RESULT_BITS-1:0]   hold_q;
    logic [RESULT_BITS-1:0]   hold_d;
    logic [RESULT_BITS-1:0]   result_q;
    logic [RESULT_BITS-1:0]   result_d;
    logic [RESULT_BITS-1:0]   frame_word_q;
    logic                     frame_clear_q;
    logic                     sdo_oe_q;
    logic                     logic_rst;
    logic                     qual_d;
    logic                     qual_fall;
    logic                     qual_rise;
    logic                     fs_qual;
    logic                     fs_rise;
    logic                     cs_fall;
    logic                     busy_fall;
    logic                     frame_start;
    logic                     timer_done;

    // Power-down acts as a reset of all control logic except the input synchroniser and the power-down entry counter.
    assign logic_rst = rst_in | pd_s;

    // Convert start is latched while chip select is low and held otherwise.
    assign qual_d    = cs_n_s ? qual_q : convert_start_n_n_s;
    assign qual_fall = qual_prev_q & ~qual_q;
    assign qual_rise = ~qual_prev_q & qual_q;

    // Frame sync is seen only with chip select low.
    assign fs_qual   = fs_s & ~cs_n_s;
    assign fs_rise   = fs_qual & ~fs_qual_prev_q;
    assign cs_fall   = cs_n_prev_q & ~cs_n_s;
    assign busy_fall = busy_prev_q & ~busy_q;
    assign timer_done = (timer_q == '0);

    // A new frame opens on select with frame sync high, on frame sync rise, or on busy fall with frame sync high.
    assign frame_start = (cs_fall & fs_s) | fs_rise | (busy_fall & fs_qual);

    always_comb begin
        state_d  = state_q;
        timer_d  = timer_done ? timer_q : timer_q - 1'b1;
        hold_d   = hold_q;
        result_d = result_q;
        case (state_q)
            SADC_PWRDN: begin
                // Leaving power-down starts the resume wait.
                state_d = SADC_RESUME;
                timer_d = TIMER_BITS'(RESUME_COUNT - 1);
            end
            SADC_RESUME: begin
                if (timer_done) begin
                    state_d = SADC_WAIT;
                end
            end
            SADC_WAIT, SADC_NAP: begin
                if (qual_rise) begin
                    state_d = SADC_SAMPLE;
                end
            end
            SADC_SAMPLE: begin
                if (qual_fall) begin
                    state_d = SADC_CONVERT;
                    timer_d = TIMER_BITS'(CONV_COUNT - 1);
                    hold_d  = sample_code_in;
                end
            end
            SADC_CONVERT: begin
                if (qual_fall) begin
                    state_d  = SADC_WAIT;
                    result_d = ABORT_WORD;
                end else if (timer_done) begin
                    result_d = hold_q;
                    if (!qual_q) begin
                        state_d = SADC_NAP;
                    end else if (!cs_n_s) begin
                        state_d = SADC_SAMPLE;
                    end else begin
                        state_d = SADC_WAIT;
                    end
                end
            end
            default: begin
                state_d = SADC_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (logic_rst) begin
            state_q  <= SADC_PWRDN;
            timer_q  <= '0;
            hold_q   <= RESULT_RESET;
            result_q <= RESULT_RESET;
        end else begin
            state_q  <= state_d;
            timer_q  <= timer_d;
            hold_q   <= hold_d;
            result_q <= result_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (logic_rst) begin
            qual_q         <= 1'b1;
            qual_prev_q    <= 1'b1;
            fs_qual_prev_q <= 1'b0;
            cs_n_prev_q    <= 1'b1;
            busy_prev_q    <= 1'b0;
        end else begin
            qual_q         <= qual_d;
            qual_prev_q    <= qual_q;
            fs_qual_prev_q <= fs_qual;
            cs_n_prev_q    <= cs_n_s;
            busy_prev_q    <= busy_q;
        end
    end

    // Busy follows the conversion state from the same edge.
    always_ff @(posedge clk_in) begin
        if (logic_rst) begin
            busy_q     <= 1'b0;
            sampling_q <= 1'b0;
            nap_q      <= 1'b0;
            ready_q    <= 1'b0;
        end else begin
            busy_q     <= (state_d == SADC_CONVERT);
            sampling_q <= (state_d == SADC_SAMPLE);
            nap_q      <= (state_d == SADC_NAP);
            ready_q    <= (state_d != SADC_PWRDN) && (state_d != SADC_RESUME);
        end
    end

    // Full power-down is reported once the entry time has elapsed.
    logic [TIMER_BITS-1:0] pd_cnt_q;

    always_ff @(posedge clk_in) begin
        if (rst_in || !pd_s) begin
            pd_cnt_q  <= TIMER_BITS'(PD_ENTRY_COUNT - 1);
            pd_done_q <= 1'b0;
        end else if (pd_cnt_q != '0) begin
            pd_cnt_q  <= pd_cnt_q - 1'b1;
        end else begin
            pd_done_q <= 1'b1;
        end
    end

    // Frame word is latched at frame start and the link is cleared with it.
    always_ff @(posedge clk_in) begin
        if (logic_rst) begin
            frame_word_q  <= RESULT_RESET;
            frame_clear_q <= 1'b1;
            sdo_oe_q      <= 1'b0;
        end else begin
            if (frame_start) begin
                frame_word_q <= result_q;
            end
            frame_clear_q <= cs_n_s | frame_start;
            sdo_oe_q      <= ~cs_n_s;
        end
    end

    assign link.frame_word  = frame_word_q;
    assign link.frame_clear = frame_clear_q;

    assign busy_out         = busy_q;
    assign sdo_out          = link.sdo;
    assign sdo_oe_out       = sdo_oe_q;
    assign sampling_out     = sampling_q;
    assign nap_out          = nap_q;
    assign powered_down_out = pd_done_q;
    assign ready_out        = ready_q;
endmodule
`default_nettype wire

//--- sadc_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module sadc_top_monitor
    import sadc_pkg::*;
#(
    parameter int unsigned RESUME_COUNT   = RESUME_CYCLES,
    parameter int unsigned PD_ENTRY_COUNT = PD_ENTRY_CYCLES,
    parameter int unsigned CONV_COUNT     = CONV_CYCLES
) (
    input wire logic                   clk_in,
    input wire logic                   rst_in,
    input wire logic                   sclk_in,
    input wire logic                   convert_start_n_in,
    input wire logic                   chip_select_n_in,
    input wire logic                   frame_sync_in,
    input wire logic                   power_down_pin_in,
    input wire logic [RESULT_BITS-1:0] sample_code_in,
    input wire logic                   busy_out,
    input wire logic                   sdo_out,
    input wire logic                   sdo_oe_out,
    input wire logic                   sampling_out,
    input wire logic                   nap_out,
    input wire logic                   powered_down_out,
    input wire logic                   ready_out
);
    int unsigned busy_cnt_q, busy_cnt_d, pd_cnt_q, pd_cnt_d, idle_cnt_q, idle_cnt_d;
    assign busy_cnt_d = (rst_in || !busy_out) ? 0 : busy_cnt_q + 1;
    assign pd_cnt_d   = (rst_in || !power_down_pin_in) ? 0 : pd_cnt_q + 1;
    assign idle_cnt_d = (rst_in || pd_cnt_q >= 3) ? 0 : idle_cnt_q + 1;
    always_ff @(posedge clk_in) begin
        busy_cnt_q <= busy_cnt_d;
        pd_cnt_q   <= pd_cnt_d;
        idle_cnt_q <= idle_cnt_d;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_oe_off;
        (chip_select_n_in || power_down_pin_in) [*4] |-> !sdo_oe_out;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");
    property p_oe_on;
        (!chip_select_n_in && !power_down_pin_in) [*4] |-> sdo_oe_out;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("sdo not driven while selected");
    property p_busy_rise;
        $rose(busy_out) |-> $past(!convert_start_n_in && !chip_select_n_in, 2);
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy rose without start");
    property p_cs_gate;
        chip_select_n_in [*7] |-> !$rose(busy_out);
    endproperty
    a_cs_gate: assert property (p_cs_gate) else $error("start taken while deselected");
    property p_busy_len;
        busy_out |-> busy_cnt_q < CONV_COUNT;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy held too long");
    property p_abort;
        busy_out && $fell(convert_start_n_in) && !chip_select_n_in |-> ##[1:7] !busy_out;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not drop busy");
    property p_nap;
        $fell(busy_out) && busy_cnt_q == CONV_COUNT && !convert_start_n_in && !$past(convert_start_n_in, 4) |-> nap_out;
    endproperty
    a_nap: assert property (p_nap) else $error("no nap after conversion");
    property p_b2b;
        $fell(busy_out) && busy_cnt_q == CONV_COUNT && convert_start_n_in && !chip_select_n_in
            && $past(convert_start_n_in, 4) && !$past(chip_select_n_in, 4) |-> sampling_out;
    endproperty
    a_b2b: assert property (p_b2b) else $error("no back to back sampling");
    property p_pd_entry;
        pd_cnt_q > 0 && pd_cnt_q <= PD_ENTRY_COUNT |-> !powered_down_out;
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("powered down too early");
    property p_resume;
        idle_cnt_q < RESUME_COUNT |-> !ready_out;
    endproperty
    a_resume: assert property (p_resume) else $error("ready before resume time");
endmodule
bind sadc_top sadc_top_monitor #(.RESUME_COUNT(RESUME_COUNT), .PD_ENTRY_COUNT(PD_ENTRY_COUNT),
    .CONV_COUNT(CONV_COUNT)) u_sadc_top_monitor (.*);
`default_nettype wire

//--- sadc_host.sv
`timescale 1ns/100ps
`default_nettype none
module sadc_host
    import sadc_pkg::*;
(
    input  wire logic                   sdo_in,
    input  wire logic                   sdo_oe_in,
    output var  logic                   sclk_out,
    output var  logic [RESULT_BITS-1:0] word_out,
    output var  logic                   done_out
);
    logic last_bit;
    logic sdo_line;
    always @* if (sdo_oe_in) last_bit = sdo_in;
    // A released line shows the inverse of its last value.
    assign sdo_line = sdo_oe_in ? sdo_in : ~last_bit;
    initial begin
        sclk_out = 1'b1;
        done_out = 1'b0;
        word_out = '0;
    end
    task automatic read_frame();
        logic [RESULT_BITS-1:0] w;
        #203;
        w = {15'd0, sdo_line};
        for (int i = 1; i < RESULT_BITS; i++) begin
            sclk_out = 1'b0;
            #6;
            sclk_out = 1'b1;
            #6;
            w = {w[RESULT_BITS-2:0], sdo_line};
        end
        word_out = w;
        done_out = 1'b1;
        #1;
        done_out = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- tb_sadc_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_sadc_top
    import sadc_pkg::*;
;
    localparam int unsigned RES = 20;
    localparam int unsigned PDE = 10;
    localparam int unsigned CNV = 25;
    logic                   clk_in, rst_in, sclk, convert_start_n, chip_select_n, frame_sync, power_down_pin;
    logic                   busy, sdo, sdo_oe, sampling, nap, powered_down, ready, rx_done;
    logic [RESULT_BITS-1:0] code, rx_word, last;
    logic [RESULT_BITS-1:0] exp_q[$];
    int                     errors, n_compared, t;
    sadc_top #(.RESUME_COUNT(RES), .PD_ENTRY_COUNT(PDE), .CONV_COUNT(CNV)) u_sadc_top (
        .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .convert_start_n_in(convert_start_n),
        .chip_select_n_in(chip_select_n), .frame_sync_in(frame_sync), .power_down_pin_in(power_down_pin),
        .sample_code_in(code), .busy_out(busy), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .sampling_out(sampling),
        .nap_out(nap), .powered_down_out(powered_down), .ready_out(ready));
    sadc_host u_sadc_host (.sdo_in(sdo), .sdo_oe_in(sdo_oe), .sclk_out(sclk), .word_out(rx_word), .done_out(rx_done));
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return busy;
            1: return ready;
            2: return powered_down;
            default: return sampling;
        endcase
    endfunction
    task automatic wait_for(input int w, input logic lvl, input int lim);
        t = 0;
        while (pick(w) !== lvl) begin
            if (t == lim) begin
                errors++;
                $display("unexpected wait on %0d expected %0d seen %0d", w, lvl, pick(w));
                wrap_up();
            end
            step(1);
            t++;
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic convert(input logic b2b, input logic abort);
        code = RESULT_BITS'($urandom);
        if (sampling !== 1'b1) begin
            convert_start_n = 1'b0;
            step(4);
        end
        convert_start_n = 1'b1;
        wait_for(3, 1'b1, 10);
        step(4);
        convert_start_n = 1'b0;
        wait_for(0, 1'b1, 10);
        check("start latency", 16'd4, 16'(t));
        if (abort) begin
            step(6);
            convert_start_n = 1'b1;
            step(4);
            convert_start_n = 1'b0;
            wait_for(0, 1'b0, 8);
            check("state after abort", 16'd0, 16'(nap | sampling));
            last = ABORT_WORD;
            chip_select_n = 1'b1;
            step(4);
            chip_select_n = 1'b0;
        end else begin
            convert_start_n = b2b;
            wait_for(0, 1'b0, CNV + 5);
            check("conversion time", 16'(CNV), 16'(t));
            check("nap", 16'(!b2b), 16'(nap));
            check("sampling", 16'(b2b), 16'(sampling));
            step(5);
            check("msb reload", 16'(code[15]), 16'(sdo));
            last = code;
        end
        exp_q.push_back(last);
        u_sadc_host.read_frame();
        $display("test conversion abort=%0d b2b=%0d done", abort, b2b);
    endtask
    always @(posedge rx_done) check("read word", exp_q.pop_front(), rx_word);
    initial begin
        {rst_in, chip_select_n, convert_start_n, frame_sync} = 4'hf;
        power_down_pin = 1'b0;
        code = '0;
        errors = 0;
        n_compared = 0;
        void'($urandom(39));
        step(3);
        rst_in = 1'b0;
        wait_for(1, 1'b1, RES + 10);
        chip_select_n = 1'b0;
        convert(1'b0, 1'b1);
        convert(1'b0, 1'b0);
        convert(1'b1, 1'b0);
        convert(1'b0, 1'b0);
        frame_sync = 1'b0;
        step(4);
        frame_sync = 1'b1;
        exp_q.push_back(last);
        u_sadc_host.read_frame();
        $display("test frame sync read done");
        chip_select_n = 1'b1;
        step(4);
        convert_start_n = 1'b1;
        step(4);
        convert_start_n = 1'b0;
        step(4);
        convert_start_n = 1'b1;
        step(6);
        check("busy deselected", 16'd0, 16'(busy));
        check("sampling deselected", 16'd0, 16'(sampling));
        chip_select_n = 1'b0;
        wait_for(3, 1'b1, 10);
        $display("test chip select gating done");
        power_down_pin = 1'b1;
        step(4);
        check("oe in power down", 16'd0, 16'(sdo_oe));
        check("ready in power down", 16'd0, 16'(ready | busy));
        wait_for(2, 1'b1, PDE + 8);
        step(4);
        power_down_pin = 1'b0;
        wait_for(1, 1'b1, RES + 10);
        convert(1'b0, 1'b0);
        convert(1'b0, 1'b0);
        $display("test power down done");
        step(4);
        wrap_up();
    end
endmodule
`default_nettype wire
